// *** rtl/pld_cfg_consts.vh ***
/*
 Constants for the configuration housekeeping block: register offsets,
 field positions, locked read pattern, response codes and power-up timing.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef PLD_CFG_CONSTS_VH
`define PLD_CFG_CONSTS_VH
`define CLK_MHZ 50
`define PUR_TIME_NS 1000
`define PUR_CYCLES ((`PUR_TIME_NS * `CLK_MHZ) / 1000)
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_SIG_LO 8'h08
`define OFF_SIG_HI 8'h0C
`define OFF_CFG_ADDR 8'h10
`define OFF_CFG_DATA 8'h14
`define OFF_PRELOAD 8'h18
`define OFF_POLARITY 8'h1C
`define OFF_OUT_EN 8'h20
`define OFF_NEXT 8'h24
`define CTRL_SECURE 0
`define CTRL_PROGRAM 1
`define CTRL_PRELOAD 2
`define CTRL_CLOCK 3
`define ST_SECURED 0
`define ST_BUSY 1
`define ST_PUR_DONE 2
`define ST_REFUSED 3
`define LOCKED_PATTERN 32'hDEADC0DE
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/pur_timer.v ***
/*
 Power-up reset timer: holds its done flag low for a fixed count of clock
 cycles after reset release. Assumes a free-running clock.
*/
`default_nettype none
module pur_timer #(
  parameter CYCLES = 50
) (
  input wire clk,
  input wire sys_rst,
  output reg done_r
);
  reg [15:0] cnt_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (cnt_r == CYCLES[15:0] - 16'h0001) begin
        done_r <= 1'b1;
      end
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pld_config_security_reset.v ***
/*
 Configuration housekeeping of a small programmable logic device: signature
 store, security cell, program/erase, register preload and power-up reset.
 Assumes an AXI4-Lite master on clk; sys_rst stands in for power-on.
*/
`default_nettype none
`include "pld_cfg_consts.vh"
module pld_config_security_reset #(
  parameter NREG = 12,
  parameter CFG_WORDS = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [NREG-1:0] out_pin_r,
  output reg [NREG-1:0] out_oe_r
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg [63:0] sig_r;
  reg secure_r;
  reg [31:0] cfg_r [0:CFG_WORDS-1];
  reg [31:0] cfg_addr_r;
  reg [31:0] prog_data_r;
  reg [1:0] state_r;
  reg [3:0] idx_r;
  reg refused_r;
  reg [NREG-1:0] q_r;
  reg [NREG-1:0] pol_r;
  reg [NREG-1:0] oe_cfg_r;
  reg [NREG-1:0] next_r;
  reg [NREG-1:0] preload_r;
  reg have_aw_r, have_w_r;
  reg [7:0] aw_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  wire pur_done;
  integer i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    begin
      merge = {st[3] ? nw[31:24] : old[31:24], st[2] ? nw[23:16] : old[23:16],
               st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  pur_timer #(.CYCLES(`PUR_CYCLES)) u_pur (
    .clk(clk),
    .sys_rst(sys_rst),
    .done_r(pur_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel
  wire wr_go = have_aw_r && have_w_r && !s_axi_bvalid;
  wire busy = (state_r != ST_IDLE);

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      aw_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      sig_r <= 64'h0000000000000000;
      secure_r <= 1'b0;
      cfg_addr_r <= 32'h00000000;
      prog_data_r <= 32'h00000000;
      state_r <= ST_IDLE;
      idx_r <= 4'h0;
      pol_r <= {NREG{1'b0}};
      oe_cfg_r <= {NREG{1'b0}};
      preload_r <= {NREG{1'b0}};
      next_r <= {NREG{1'b0}};
      q_r <= {NREG{1'b0}};
      for (i = 0; i < CFG_WORDS; i = i + 1) begin
        cfg_r[i] <= 32'h00000000;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_r <= 1'b1;
        aw_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Programming engine: erase every word, then write the image word
      case (state_r)
        ST_ERASE: begin
          cfg_r[idx_r] <= 32'h00000000;
          if (idx_r == CFG_WORDS[3:0] - 4'h1) begin
            state_r <= ST_WRITE;
          end
          idx_r <= idx_r + 4'h1;
        end
        ST_WRITE: begin
          cfg_r[cfg_addr_r[3:0]] <= prog_data_r;
          secure_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (pur_done) begin
        if (wr_go && aw_r == `OFF_CTRL && ws_r[0] && wd_r[`CTRL_PRELOAD]) begin
          q_r <= preload_r;
        end else if (wr_go && aw_r == `OFF_CTRL && ws_r[0] && wd_r[`CTRL_CLOCK]) begin
          q_r <= next_r;
        end
      end
      if (wr_go) begin
        have_aw_r <= 1'b0;
        have_w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case (aw_r)
          `OFF_CTRL: begin
            if (ws_r[0] && wd_r[`CTRL_SECURE]) begin
              secure_r <= 1'b1;
            end
            if (ws_r[0] && wd_r[`CTRL_PROGRAM] && !busy) begin
              state_r <= ST_ERASE;
              idx_r <= 4'h0;
            end
          end
          `OFF_SIG_LO: sig_r[31:0] <= merge(sig_r[31:0], wd_r, ws_r);
          `OFF_SIG_HI: sig_r[63:32] <= merge(sig_r[63:32], wd_r, ws_r);
          `OFF_CFG_ADDR: cfg_addr_r <= merge(cfg_addr_r, wd_r, ws_r);
          `OFF_CFG_DATA: prog_data_r <= merge(prog_data_r, wd_r, ws_r);
          `OFF_PRELOAD: preload_r <= wd_r[NREG-1:0];
          `OFF_POLARITY: pol_r <= wd_r[NREG-1:0];
          `OFF_OUT_EN: oe_cfg_r <= wd_r[NREG-1:0];
          `OFF_NEXT: next_r <= wd_r[NREG-1:0];
          `OFF_STATUS: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  reg [31:0] rd_nxt;
  reg [1:0] rresp_nxt;
  reg refuse_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    rresp_nxt = `RESP_OKAY;
    refuse_nxt = 1'b0;
    case (s_axi_araddr)
      `OFF_CTRL: rd_nxt = 32'h00000000;
      `OFF_STATUS: begin
        rd_nxt[`ST_SECURED] = secure_r;
        rd_nxt[`ST_BUSY] = busy;
        rd_nxt[`ST_PUR_DONE] = pur_done;
        rd_nxt[`ST_REFUSED] = refused_r;
      end
      `OFF_SIG_LO: rd_nxt = sig_r[31:0];
      `OFF_SIG_HI: rd_nxt = sig_r[63:32];
      `OFF_CFG_ADDR: rd_nxt = cfg_addr_r;
      `OFF_CFG_DATA: begin
        if (secure_r) begin
          rd_nxt = `LOCKED_PATTERN;
          refuse_nxt = 1'b1;
        end else begin
          rd_nxt = cfg_r[cfg_addr_r[3:0]];
        end
      end
      `OFF_PRELOAD: rd_nxt[NREG-1:0] = preload_r;
      `OFF_POLARITY: rd_nxt[NREG-1:0] = pol_r;
      `OFF_OUT_EN: rd_nxt[NREG-1:0] = oe_cfg_r;
      `OFF_NEXT: rd_nxt[NREG-1:0] = q_r;
      default: rresp_nxt = `RESP_SLVERR;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
      refused_r <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rresp_nxt;
        if (refuse_nxt) begin
          refused_r <= 1'b1;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pins: polarity applied to register state
  always @(posedge clk) begin
    if (sys_rst) begin
      out_pin_r <= {NREG{1'b0}};
      out_oe_r <= {NREG{1'b0}};
    end else begin
      out_pin_r <= q_r ^ pol_r;
      out_oe_r <= oe_cfg_r;
    end
  end
endmodule
`default_nettype wire

// *** tb/pld_cfg_master.sv ***
/* AXI4-Lite master standing in for the device programmer or tester.
 Assumes the block's slave port on clk; the bench calls wr and rd. */
`default_nettype none
module pld_cfg_master (
  input wire logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/pld_config_security_reset_asserts.sv ***
/* Port-level checks on the configuration housekeeping block.
 Assumes the bind at the foot of this file. */
`default_nettype none
module pld_cfg_watch #(
  parameter int NREG = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NREG-1:0] out_pin_r,
  input wire logic [NREG-1:0] out_oe_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_clear_a: assert property ($fell(sys_rst) |-> out_oe_r == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state left after reset");
  pin_clear_a: assert property ($fell(sys_rst) |-> out_pin_r == '0)
    else $error("pins not cleared by reset");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  r_free_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while busy");
  b_free_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not released");
endmodule
bind pld_config_security_reset pld_cfg_watch #(.NREG(NREG)) u_watch (.*);
`default_nettype wire

// *** tb/pld_config_security_reset_test.sv ***
/* Self-checking bench for the configuration housekeeping block.
 Assumes the master model and the bound checker are compiled alongside. */
`default_nettype none
`include "pld_cfg_consts.vh"
module pld_config_security_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [11:0] out_pin_r, out_oe_r;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  pld_config_security_reset i_dut (.*);
  pld_cfg_master m (.*);
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    m.rd(a, rd_v, rd_r);
    chk(rd_v, exp);
  endtask
  task automatic prog(input logic [31:0] a, d);
    m.wr(`OFF_CFG_ADDR, a);
    m.wr(`OFF_CFG_DATA, d);
    m.wr(`OFF_CTRL, 32'h2);
    do m.rd(`OFF_STATUS, rd_v, rd_r); while (rd_v[`ST_BUSY] !== 1'b0);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic t_reset;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chk(32'(out_pin_r), 32'h0);
    rdc(`OFF_SIG_LO, 32'h0);
    rdc(`OFF_STATUS, 32'h0);
    repeat (`PUR_CYCLES) @(posedge clk);
    rdc(`OFF_STATUS, 32'h4);
    $display("reset done");
  endtask
  task automatic t_pre;
    m.wr(`OFF_POLARITY, 32'hA5A);
    m.wr(`OFF_OUT_EN, 32'hFFF);
    chk(32'(out_pin_r), 32'hA5A);
    m.wr(`OFF_PRELOAD, 32'h3C6);
    m.wr(`OFF_CTRL, 32'h4);
    rdc(`OFF_NEXT, 32'h3C6);
    chk(32'(out_pin_r), 32'h99C);
    chk(32'(out_oe_r), 32'hFFF);
    m.wr(`OFF_NEXT, 32'h0F0);
    m.wr(`OFF_CTRL, 32'h8);
    rdc(`OFF_NEXT, 32'h0F0);
    chk(32'(out_pin_r), 32'hAAA);
    $display("preload done");
  endtask
  task automatic t_sig;
    prog(32'h2, 32'h1357_9BDF);
    rdc(`OFF_CFG_DATA, 32'h1357_9BDF);
    m.wr(`OFF_SIG_LO, 32'h0123_4567);
    m.wr(`OFF_SIG_HI, 32'h89AB_CDEF);
    chk(32'(s_axi_bresp), 32'(`RESP_OKAY));
    m.wr(`OFF_CTRL, 32'h1);
    rdc(`OFF_SIG_LO, 32'h0123_4567);
    rdc(`OFF_SIG_HI, 32'h89AB_CDEF);
    rdc(`OFF_CFG_DATA, `LOCKED_PATTERN);
    chk(32'(rd_r), 32'(`RESP_OKAY));
    rdc(`OFF_STATUS, 32'hD);
    m.rd(8'h30, rd_v, rd_r);
    chk(32'(rd_r), 32'(`RESP_SLVERR));
    m.wr(8'h30, 32'h0);
    chk(32'(s_axi_bresp), 32'(`RESP_SLVERR));
    $display("secure done");
  endtask
  task automatic t_prog;
    prog(32'h5, 32'h2468_ACE0);
    rdc(`OFF_STATUS, 32'hC);
    rdc(`OFF_CFG_DATA, 32'h2468_ACE0);
    m.wr(`OFF_CFG_ADDR, 32'h2);
    rdc(`OFF_CFG_DATA, 32'h0);
    $display("program done");
  endtask
  initial begin
    t_reset();
    t_pre();
    t_sig();
    t_prog();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
